// ==== design/trr_pkg.sv ====
// Package for the temperature readout registers: map, field layout, carriers
package trr_pkg;
   localparam int TRR_ADDR_W = 6;
   localparam logic [5:0] TRR_OFS_CAPS = 6'h08;
   localparam logic [5:0] TRR_OFS_RESULT = 6'h09;
   localparam logic [15:0] TRR_CAPS_VALUE = 16'h0549;
   localparam logic [15:0] TRR_RESULT_RESET = 16'h0000;
   localparam logic [15:0] TRR_UNMAPPED_DATA = 16'h0000;
   // Capabilities fields
   localparam int TRR_CAP_RES_LSB = 0;
   localparam logic [2:0] TRR_CAP_RES_HALF_DEG = 3'h1;
   localparam int TRR_CAP_NBITS_LSB = 3;
   localparam logic [2:0] TRR_CAP_NBITS_TEN = 3'h1;
   localparam int TRR_CAP_SIGN_BIT = 6;
   localparam int TRR_CAP_WIDTH_BIT = 7;
   localparam int TRR_CAP_ONDIE_BIT = 8;
   localparam int TRR_CAP_REMOTES_LSB = 9;
   localparam logic [2:0] TRR_CAP_REMOTES = 3'h2;
   // Result word fields
   localparam int TRR_TEMP_W = 10;
   localparam logic [9:0] TRR_TEMP_FAULT = 10'h200;
   localparam logic [1:0] TRR_SENSOR_ON_DIE = 2'h0;
   localparam logic [1:0] TRR_SENSOR_LAST = 2'h2;
   localparam int TRR_NUM_SENSORS = 3;

   typedef struct packed {
      logic [9:0] temperature;
      logic [1:0] reserved_hi;
      logic [1:0] source_sensor_index;
      logic remote_fault_flag;
      logic reserved_lo;
   } trr_result_word_t;

   typedef struct packed {
      logic valid;
      logic [9:0] temperature;
      logic fault;
   } trr_conversion_t;

   typedef struct packed {
      logic strobe;
      logic [5:0] addr;
   } trr_read_req_t;
endpackage

// ==== design/trr_temp_readout.sv ====
// Temperature capabilities and readout registers with scan order and flags
// Functional notes
// - Capabilities at 08h read fixed 0549h
// - Resolution field reads 001, half degree
// - Bit-count field reads 001, ten bits
// - Bit 6 set: signed two's complement
// - Bit 7 clear: sixteen-bit readout word
// - Bit 8 set: on-die sensor present
// - Bits 11-9 report two remote sensors
// - Readout at 09h, temperature in 15-6
// - Bits 3-2 hold source sensor index
// - On-die result returns fault bit zero
// - Remote result fault bit marks diode fault
// - Diode fault forces temperature 200h
// - Bits 5-4 and 0 read zero
// - One signed half-degree encoding for all
// - Readout read clears new-result flag
// - Unread overwrite sets overrun, read clears
// - Ascending round-robin over enabled sensors
`timescale 1ns/1ps
module trr_temp_readout (
   input wire logic i_clk_sys, // System clock, 100 MHz
   input wire logic i_resetn, // Synchronous reset, active low
   input wire trr_pkg::trr_conversion_t i_conv, // Finished conversion from front end
   input wire logic [2:0] i_sensor_enable, // Per-sensor scan enables
   input wire trr_pkg::trr_read_req_t i_rd, // Register read request
   output logic [15:0] o_rd_data, // Read data
   output logic o_rd_valid, // Read data valid pulse
   output logic [1:0] o_scan_sensor, // Sensor the front end measures now
   output logic o_temp_new_result_flag, // New result waiting
   output logic o_temp_overrun_flag // Result overwritten unread
);
   import trr_pkg::*;

   trr_result_word_t result_word;
   trr_result_word_t next_result_word;
   logic [1:0] scan_sensor;
   logic [1:0] next_scan_sensor;
   logic new_flag;
   logic next_new_flag;
   logic overrun_flag;
   logic next_overrun_flag;
   logic [15:0] rd_data;
   logic [15:0] next_rd_data;
   logic rd_valid;
   logic next_rd_valid;
   logic result_read;
   logic [15:0] caps_word;

   // Next enabled sensor after cur, wrapping; cur itself if it is the sole one or none is enabled
   function automatic logic [1:0] f_next_sensor(input logic [1:0] cur, input logic [2:0] en);
      logic [2:0] cand;
      logic [1:0] pick;
      pick = cur;
      for (int k = TRR_NUM_SENSORS; k >= 1; k--) begin
         cand = {1'b0, cur} + 3'(k);
         if (cand >= 3'(TRR_NUM_SENSORS)) begin
            cand = cand - 3'(TRR_NUM_SENSORS);
         end
         if (en[cand[1:0]]) begin
            pick = cand[1:0];
         end
      end
      return pick;
   endfunction

   always_comb begin
      caps_word = 16'h0000;
      caps_word[TRR_CAP_RES_LSB +: 3] = TRR_CAP_RES_HALF_DEG;
      caps_word[TRR_CAP_NBITS_LSB +: 3] = TRR_CAP_NBITS_TEN;
      caps_word[TRR_CAP_SIGN_BIT] = 1'b1;
      caps_word[TRR_CAP_WIDTH_BIT] = 1'b0;
      caps_word[TRR_CAP_ONDIE_BIT] = 1'b1;
      caps_word[TRR_CAP_REMOTES_LSB +: 3] = TRR_CAP_REMOTES;
   end

   assign result_read = i_rd.strobe && (i_rd.addr == TRR_OFS_RESULT);

   // Read port
   always_comb begin
      next_rd_valid = i_rd.strobe;
      next_rd_data = rd_data;
      if (i_rd.strobe) begin
         if (i_rd.addr == TRR_OFS_CAPS) begin
            next_rd_data = caps_word;
         end else if (i_rd.addr == TRR_OFS_RESULT) begin
            next_rd_data = result_word;
         end else begin
            next_rd_data = TRR_UNMAPPED_DATA;
         end
      end
   end

   // Result capture and flags
   always_comb begin
      next_result_word = result_word;
      next_new_flag = new_flag;
      next_overrun_flag = overrun_flag;
      next_scan_sensor = scan_sensor;
      if (!i_sensor_enable[scan_sensor]) begin
         next_scan_sensor = f_next_sensor(scan_sensor, i_sensor_enable);
      end
      if (result_read) begin
         next_new_flag = 1'b0;
         next_overrun_flag = 1'b0;
      end
      if (i_conv.valid) begin
         // Whole word loaded in one edge so a read never mixes two conversions
         next_result_word.temperature = i_conv.temperature;
         next_result_word.reserved_hi = 2'h0;
         next_result_word.source_sensor_index = scan_sensor;
         next_result_word.reserved_lo = 1'b0;
         next_result_word.remote_fault_flag = 1'b0;
         if (scan_sensor != TRR_SENSOR_ON_DIE && i_conv.fault) begin
            next_result_word.remote_fault_flag = 1'b1;
            next_result_word.temperature = TRR_TEMP_FAULT;
         end
         // A conversion in the same cycle as the read keeps its flag set
         next_new_flag = 1'b1;
         if (new_flag && !result_read) begin
            next_overrun_flag = 1'b1;
         end
         next_scan_sensor = f_next_sensor(scan_sensor, i_sensor_enable);
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         result_word <= TRR_RESULT_RESET;
         new_flag <= 1'b0;
         overrun_flag <= 1'b0;
         scan_sensor <= TRR_SENSOR_ON_DIE;
         rd_data <= 16'h0000;
         rd_valid <= 1'b0;
      end else begin
         result_word <= next_result_word;
         new_flag <= next_new_flag;
         overrun_flag <= next_overrun_flag;
         scan_sensor <= next_scan_sensor;
         rd_data <= next_rd_data;
         rd_valid <= next_rd_valid;
      end
   end

   assign o_rd_data = rd_data;
   assign o_rd_valid = rd_valid;
   assign o_scan_sensor = scan_sensor;
   assign o_temp_new_result_flag = new_flag;
   assign o_temp_overrun_flag = overrun_flag;

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_resetn);

   sequence s_caps_read;
      i_rd.strobe && i_rd.addr == TRR_OFS_CAPS;
   endsequence
   sequence s_result_read;
      i_rd.strobe && i_rd.addr == TRR_OFS_RESULT;
   endsequence
   sequence s_conv_remote_fault;
      i_conv.valid && i_conv.fault && scan_sensor != TRR_SENSOR_ON_DIE;
   endsequence

   property p_caps_value;
      s_caps_read |=> o_rd_valid && o_rd_data == 16'h0549 && o_rd_data[15:12] == 4'h0;
   endproperty
   a_caps_value: assert property (p_caps_value) else $error("caps word wrong");
   property p_caps_res;
      s_caps_read |=> o_rd_data[2:0] == 3'h1;
   endproperty
   a_caps_res: assert property (p_caps_res) else $error("resolution field wrong");
   property p_caps_nbits;
      s_caps_read ##1 o_rd_valid |-> o_rd_data[5:3] == 3'h1;
   endproperty
   a_caps_nbits: assert property (p_caps_nbits) else $error("bit count wrong");
   property p_caps_sign;
      s_caps_read |=> o_rd_data[6];
   endproperty
   a_caps_sign: assert property (p_caps_sign) else $error("sign bit clear");
   property p_caps_width;
      s_caps_read |=> !o_rd_data[7];
   endproperty
   a_caps_width: assert property (p_caps_width) else $error("width bit set");
   property p_caps_ondie;
      s_caps_read |=> o_rd_data[8] && o_rd_valid;
   endproperty
   a_caps_ondie: assert property (p_caps_ondie) else $error("on-die bit clear");
   property p_caps_remotes;
      s_caps_read |=> o_rd_data[11:9] == 3'h2;
   endproperty
   a_caps_remotes: assert property (p_caps_remotes) else $error("remote count wrong");
   property p_result_read;
      s_result_read ##0 (!i_conv.valid) ##1 i_rd.strobe == 1'b0 |->
         o_rd_data == $past(result_word);
   endproperty
   a_result_read: assert property (p_result_read) else $error("readout data wrong");
   property p_index;
      i_conv.valid |=> result_word.source_sensor_index == $past(scan_sensor);
   endproperty
   a_index: assert property (p_index) else $error("sensor index wrong");
   property p_ondie_nofault;
      result_word.source_sensor_index == TRR_SENSOR_ON_DIE |-> !result_word.remote_fault_flag;
   endproperty
   a_ondie_nofault: assert property (p_ondie_nofault) else $error("on-die fault bit");
   property p_remote_fault;
      i_conv.valid && scan_sensor != TRR_SENSOR_ON_DIE |=>
         result_word.remote_fault_flag == $past(i_conv.fault);
   endproperty
   a_remote_fault: assert property (p_remote_fault) else $error("fault flag wrong");
   property p_fault_code;
      s_conv_remote_fault |=> result_word.temperature == 10'h200;
   endproperty
   a_fault_code: assert property (p_fault_code) else $error("fault code wrong");
   property p_reserved;
      result_word.reserved_hi == 2'h0 && !result_word.reserved_lo;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits set");
   property p_encoding;
      i_conv.valid && !i_conv.fault |=> result_word.temperature == $past(i_conv.temperature);
   endproperty
   a_encoding: assert property (p_encoding) else $error("temperature altered");
   property p_read_clears;
      s_result_read ##0 !i_conv.valid |=> !o_temp_new_result_flag && !o_temp_overrun_flag;
   endproperty
   a_read_clears: assert property (p_read_clears) else $error("flags not cleared");
   property p_overrun;
      i_conv.valid && o_temp_new_result_flag && !result_read |=> o_temp_overrun_flag;
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun not set");
   property p_round_robin;
      i_conv.valid && i_sensor_enable == 3'h7 |=>
         scan_sensor == (($past(scan_sensor) == TRR_SENSOR_LAST) ?
            2'h0 : $past(scan_sensor) + 2'h1);
   endproperty
   a_round_robin: assert property (p_round_robin) else $error("scan order wrong");
   property p_atomic;
      !i_conv.valid |=> $stable(result_word);
   endproperty
   a_atomic: assert property (p_atomic) else $error("word changed without result");
endmodule // trr_temp_readout

// ==== verif/trr_bus_master.sv ====
// Behavioural sensor bus master: one read per request, captures the answer
`timescale 1ns/1ps
module trr_bus_master (
   input wire logic i_clk_sys, // System clock
   input wire logic i_go, // Start one read, sampled on the rising edge
   input wire logic [5:0] i_addr, // Register to read
   input wire logic i_rd_valid, // Answer strobe from the device
   input wire logic [15:0] i_rd_data, // Answer data from the device
   output trr_pkg::trr_read_req_t o_rd, // Read request to the device
   output logic [15:0] o_data, // Last word captured
   output logic o_done // Capture done pulse
);
   import trr_pkg::*;
   initial begin
      o_rd = '0;
      o_data = '0;
      o_done = 1'b0;
   end
   always @(posedge i_clk_sys) begin
      o_done <= i_rd_valid;
      if (i_rd_valid) begin
         o_data <= i_rd_data;
      end
      // Released address toggles so a stale value never looks valid
      if (i_go) begin
         o_rd <= '{1'b1, i_addr};
      end else begin
         o_rd <= '{1'b0, ~o_rd.addr};
      end
   end
endmodule // trr_bus_master

// ==== verif/tb.sv ====
// Self-checking bench for the temperature readout registers
`timescale 1ns/1ps
module tb;
   import trr_pkg::*;
   typedef struct {logic [9:0] t; logic f; logic [15:0] w;} trr_row_t;
   logic i_clk_sys = 1'b0;
   logic i_resetn = 1'b0;
   trr_conversion_t i_conv = '0;
   logic [2:0] i_sensor_enable = 3'h7;
   trr_read_req_t i_rd;
   logic [15:0] o_rd_data, m_data, rd_word;
   logic o_rd_valid, o_temp_new_result_flag, o_temp_overrun_flag, m_done;
   logic [1:0] o_scan_sensor;
   logic go = 1'b0;
   logic [5:0] go_addr = 6'h00;
   int n_mismatch = 0;
   int checks_done = 0;
   // Scan runs 0,1,2,0,1; sensor 0 ignores fault, remote fault forces 200h
   trr_row_t rows [5] = '{'{10'h0c8, 1'b0, 16'h3200}, '{10'h3ff, 1'b0, 16'hffc4},
      '{10'h118, 1'b1, 16'h800a}, '{10'h2b0, 1'b1, 16'hac00}, '{10'h201, 1'b0, 16'h8044}};
   always #5 i_clk_sys = ~i_clk_sys;
   trr_temp_readout DUT (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_conv(i_conv),
      .i_sensor_enable(i_sensor_enable), .i_rd(i_rd), .o_rd_data(o_rd_data),
      .o_rd_valid(o_rd_valid), .o_scan_sensor(o_scan_sensor),
      .o_temp_new_result_flag(o_temp_new_result_flag),
      .o_temp_overrun_flag(o_temp_overrun_flag));
   trr_bus_master master (.i_clk_sys(i_clk_sys), .i_go(go), .i_addr(go_addr),
      .i_rd_valid(o_rd_valid), .i_rd_data(o_rd_data), .o_rd(i_rd), .o_data(m_data),
      .o_done(m_done));
   task automatic results();
      $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic flags(input logic [1:0] exp);
      chk({14'h0, o_temp_new_result_flag, o_temp_overrun_flag}, {14'h0, exp}, "flags");
   endtask
   task automatic rd(input logic [5:0] addr);
      @(negedge i_clk_sys);
      go = 1'b1;
      go_addr = addr;
      @(negedge i_clk_sys);
      go = 1'b0;
      for (int i = 0; i < 6 && m_done !== 1'b1; i++) @(negedge i_clk_sys);
      if (m_done !== 1'b1) begin
         n_mismatch++;
         $display("Error at %0t: read answer missing", $time);
         results();
      end
      rd_word = m_data;
   endtask
   // Data lines carry inverted junk once the conversion strobe drops
   task automatic conv(input logic [9:0] t, input logic f);
      @(negedge i_clk_sys);
      i_conv = '{1'b1, t, f};
      @(negedge i_clk_sys);
      i_conv = '{1'b0, ~t, ~f};
   endtask
   initial begin
      repeat (12) @(negedge i_clk_sys);
      i_resetn = 1'b1;
      chk(o_rd_data, 16'h0000, "reset data");
      chk({14'h0, o_scan_sensor}, 16'h0000, "reset scan");
      flags(2'b00);
      rd(TRR_OFS_CAPS);
      chk(rd_word, 16'h0549, "caps");
      chk({13'h0, rd_word[2:0]}, 16'h0001, "resolution");
      chk({13'h0, rd_word[5:3]}, 16'h0001, "bit count");
      chk({13'h0, rd_word[11:9]}, 16'h0002, "remotes");
      // Unmapped read right after the capabilities word, so stale data would show
      rd(6'h3f);
      chk(rd_word, 16'h0000, "unmapped");
      rd(TRR_OFS_RESULT);
      chk(rd_word, 16'h0000, "readout after reset");
      $display("Register map test done");
      foreach (rows[i]) begin
         conv(rows[i].t, rows[i].f);
         flags(2'b10);
         rd(TRR_OFS_RESULT);
         chk(rd_word, rows[i].w, "readout");
         flags(2'b00);
         $display("Row %0d done", i);
      end
      // Sensor 1 disabled: scan must go 2 then 0 then back to 2
      @(negedge i_clk_sys);
      i_sensor_enable = 3'h5;
      conv(10'h002, 1'b0);
      conv(10'h3fe, 1'b1);
      flags(2'b11);
      chk({14'h0, o_scan_sensor}, 16'h0002, "skip scan");
      rd(TRR_OFS_RESULT);
      chk(rd_word, 16'hff80, "overwrite");
      flags(2'b00);
      $display("Skip and overrun test done");
      @(negedge i_clk_sys);
      i_resetn = 1'b0;
      @(negedge i_clk_sys);
      i_resetn = 1'b1;
      chk({14'h0, o_scan_sensor}, 16'h0000, "mid reset scan");
      rd(TRR_OFS_RESULT);
      chk(rd_word, 16'h0000, "mid reset readout");
      conv(10'h0c8, 1'b0);
      rd(TRR_OFS_RESULT);
      chk(rd_word, 16'h3200, "after reset");
      $display("Mid-run reset test done");
      // Current sensor disabled while idle: scan leaves it at the next edge
      @(negedge i_clk_sys);
      i_sensor_enable = 3'h3;
      @(negedge i_clk_sys);
      chk({14'h0, o_scan_sensor}, 16'h0000, "idle skip");
      conv(10'h0c8, 1'b0);
      // Read and conversion at one edge: old word read, new flag stays, no overrun
      fork
         rd(TRR_OFS_RESULT);
         begin
            @(negedge i_clk_sys);
            conv(10'h002, 1'b1);
         end
      join
      chk(rd_word, 16'h3200, "read beside result");
      flags(2'b10);
      rd(TRR_OFS_RESULT);
      chk(rd_word, 16'h8006, "remote fault");
      flags(2'b00);
      $display("Coincident read test done");
      results();
   end
endmodule // tb
